// ---- hw/wsws_pkg.sv ----
/*
  Shared constants and types of the weld schedule sequencer.
  Assumes all users reference names as wsws_pkg::name.
*/
package wsws_pkg;
  // Schedule table geometry
  localparam int          SCHED_COUNT  = 100;
  localparam logic [6:0]  SCHED_LAST   = 7'h63;
  localparam logic [6:0]  SCHED_BR_A   = 7'h14;  // Branch A target, schedule 20
  localparam logic [6:0]  SCHED_BR_B   = 7'h28;  // Branch B target, schedule 40
  // Field offsets inside one schedule slot, address bits 3:0
  localparam logic [3:0]  F_SQZ        = 4'h0;
  localparam logic [3:0]  F_WELD       = 4'h1;
  localparam logic [3:0]  F_PCT        = 4'h2;
  localparam logic [3:0]  F_HOLD       = 4'h3;
  localparam logic [3:0]  F_OFF        = 4'h4;
  localparam logic [3:0]  F_IMP        = 4'h5;
  localparam logic [3:0]  F_COOL       = 4'h6;
  localparam logic [3:0]  F_VALVE      = 4'h7;
  localparam logic [3:0]  F_CYC        = 4'h8;
  localparam logic [3:0]  F_SLM        = 4'h9;
  localparam logic [3:0]  F_SLC        = 4'hA;
  localparam logic [3:0]  F_CONT       = 4'hB;
  // Control registers, address bit 11 set
  localparam logic [11:0] A_OPTION     = 12'h800;
  localparam logic [11:0] A_START      = 12'h801;
  localparam logic [11:0] A_STAT_SCHED = 12'h802;
  localparam logic [11:0] A_STAT_STATE = 12'h803;
  localparam logic [7:0]  OPTION_RST   = 8'h00;
  localparam logic [6:0]  START_RST    = 7'h00;
  // Codes
  localparam logic [7:0]  CM_NONREP    = 8'h00;
  localparam logic [7:0]  CM_REPEAT    = 8'h01;
  localparam logic [7:0]  CM_CHAIN     = 8'h02;
  localparam logic [7:0]  CM_SUCC      = 8'h03;
  localparam logic [7:0]  CM_CONDSUCC  = 8'h04;
  localparam logic [7:0]  CM_WAIT      = 8'h05;
  localparam logic [7:0]  OPT_WAIT_EN  = 8'h05;
  localparam logic [7:0]  SM_UP        = 8'h01;
  localparam logic [7:0]  SM_DOWN      = 8'h02;
  localparam logic [7:0]  WAIT_MARK    = 8'h63;  // 99 marks the wait point
  localparam logic [7:0]  SLOPE_MAX    = 8'h63;
  localparam logic [7:0]  CONT_2       = 8'h02;
  localparam logic [7:0]  BLINK_TICKS  = 8'h1E;  // Lamp half period in line ticks

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_SQZ = 8'h02, ST_UPS = 8'h04, ST_WELD = 8'h08,
    ST_COOL = 8'h10, ST_DNS = 8'h20, ST_HOLD = 8'h40, ST_CSW = 8'h80
  } wsws_state_type;

  // One schedule; squeeze sits in the low byte so field N is byte N
  typedef struct packed {
    logic [7:0] cont, slc, slm, cyc, valve, cool, imp, off, hold, pct, weld, sqz;
  } wsws_sched_type;

  // Machine pins after synchronising
  typedef struct packed {
    logic prim, br_a, br_b, estop_ok, temp_ok, tick;
  } wsws_pins_type;
endpackage : wsws_pkg

// ---- hw/wsws_sync.sv ----
/*
  Two-flop synchroniser for a vector of slow machine inputs.
  Assumes inputs are unrelated to the clock and change slowly.
*/
module wsws_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // One flop pair per bit; first stage feeds only the second
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_q[g] <= 1'b0;
        q_o[g]    <= 1'b0;
      end else begin
        meta_q[g] <= d_i[g];
        q_o[g]    <= meta_q[g];
      end
    end
  end
endmodule : wsws_sync

// ---- hw/wsws_ramp.sv ----
/*
  Slope current generator: divides the span by the slope count once,
  then steps the level each line tick.
  Assumes load comes long before the first tick (line tick is slow).
*/
module wsws_ramp (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       load_i,
  input  wire logic       up_i,
  input  wire logic       step_i,
  input  wire logic [7:0] pct_i,
  input  wire logic [7:0] count_i,
  // Level
  output logic      [7:0] level_o
);
  logic [7:0] lvl_q, lvl_d, quo_q, quo_d, rem_q, rem_d, div_q, div_d;
  logic [3:0] bit_q, bit_d;
  logic       up_q, up_d;
  logic [8:0] trial;

  // Start at a quarter (up) or full (down); span divided bit by bit
  always_comb begin
    lvl_d = lvl_q; quo_d = quo_q; rem_d = rem_q; div_d = div_q;
    bit_d = bit_q; up_d  = up_q;
    trial = {rem_q, quo_q[7]};
    if (load_i) begin
      up_d  = up_i;
      lvl_d = up_i ? {2'b00, pct_i[7:2]} : pct_i;
      quo_d = pct_i - {2'b00, pct_i[7:2]};
      rem_d = 8'h00;
      div_d = (count_i == 8'h00) ? 8'h01 : count_i;
      bit_d = 4'h8;
    end else if (bit_q != 4'h0) begin
      if (trial >= {1'b0, div_q}) begin
        rem_d = 8'(trial - {1'b0, div_q});
        quo_d = {quo_q[6:0], 1'b1};
      end else begin
        rem_d = trial[7:0];
        quo_d = {quo_q[6:0], 1'b0};
      end
      bit_d = bit_q - 4'h1;
      if (bit_q == 4'h1 && !up_q) lvl_d = lvl_q - quo_d;
    end else if (step_i) begin
      lvl_d = up_q ? lvl_q + quo_q : lvl_q - quo_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_q <= 8'h00; quo_q <= 8'h00; rem_q <= 8'h00; div_q <= 8'h01;
      bit_q <= 4'h0;  up_q  <= 1'b0;
    end else begin
      lvl_q <= lvl_d; quo_q <= quo_d; rem_q <= rem_d; div_q <= div_d;
      bit_q <= bit_d; up_q  <= up_d;
    end
  end

  assign level_o = lvl_q;
endmodule : wsws_ramp

// ---- hw/wsws_top.sv ----
/*
  Weld schedule sequencer: schedule table, phase timing on line ticks,
  chaining, conditional successive, wait-here, slope current.
  Assumes a line-synchronous tick pin and a simple register port.
*/
// Our own choices: strobed register access and the placing of the registers.
module wsws_top (
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  // Register port
  input  wire logic [11:0] ADDR_I,
  input  wire logic [7:0]  WR_DATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RD_DATA_O,
  // Machine inputs
  input  wire logic        PRIMARY_INITIATE_INPUT_I,
  input  wire logic        BRANCH_A_INITIATE_INPUT_I,
  input  wire logic        BRANCH_B_INITIATE_INPUT_I,
  input  wire logic        ESTOP_CLOSED_I,
  input  wire logic        TEMP_LIMIT_CLOSED_I,
  input  wire logic        LINE_TICK_I,
  // Machine outputs
  output logic      [7:0]  VALVE_O,
  output logic             CONTACTOR1_O,
  output logic             CONTACTOR2_O,
  output logic      [7:0]  CURRENT_O,
  output logic             HOLD_LAMP_O,
  output logic      [6:0]  SCHED_O
);
  wsws_pkg::wsws_sched_type mem [wsws_pkg::SCHED_COUNT];
  wsws_pkg::wsws_sched_type cur;
  wsws_pkg::wsws_pins_type  pin, pin_p_q;
  wsws_pkg::wsws_state_type st_q, st_d;
  logic [5:0] pin_v;
  logic [6:0] sched_q, sched_d, first_q, first_d, start_q, start_d, idx;
  logic [7:0] cnt_q, cnt_d, imp_q, imp_d, opt_q, opt_d, blink_q, blink_d;
  logic [7:0] tgt, rd_d, ramp_lvl, cur_d, valve_d;
  logic       lamp_q, lamp_d, c1_d, c2_d, done, ok, wait_sqz, wait_wc, wait_hold;
  logic       in_wait, mem_we, accept, prim_r, bra_r, brb_r, tick, ramp_load;

  // Pins pass two flops before use
  wsws_sync #(.W(6)) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     ({PRIMARY_INITIATE_INPUT_I, BRANCH_A_INITIATE_INPUT_I,
               BRANCH_B_INITIATE_INPUT_I, ESTOP_CLOSED_I, TEMP_LIMIT_CLOSED_I,
               LINE_TICK_I}),
    .q_o     (pin_v)
  );
  assign pin    = wsws_pkg::wsws_pins_type'(pin_v);
  assign prim_r = pin.prim & ~pin_p_q.prim;
  assign bra_r  = pin.br_a & ~pin_p_q.br_a;
  assign brb_r  = pin.br_b & ~pin_p_q.br_b;
  assign tick   = pin.tick & ~pin_p_q.tick;
  assign ok     = pin.estop_ok & pin.temp_ok;
  assign cur    = mem[sched_q];
  assign idx    = ADDR_I[10:4];

  // Programmed length of the phase now running
  function automatic logic [7:0] phase_len(input wsws_pkg::wsws_state_type s,
                                           input wsws_pkg::wsws_sched_type c);
    case (s)
      wsws_pkg::ST_SQZ:  phase_len = c.sqz;
      wsws_pkg::ST_UPS,
      wsws_pkg::ST_DNS:  phase_len = c.slc;
      wsws_pkg::ST_WELD: phase_len = c.weld;
      wsws_pkg::ST_COOL: phase_len = c.cool;
      wsws_pkg::ST_HOLD: phase_len = c.hold;
      default:           phase_len = 8'h00;
    endcase
  endfunction : phase_len

  // Wait point chosen by a field at 99, in priority order
  assign wait_sqz  = (cur.cyc == wsws_pkg::CM_WAIT) && (cur.sqz == wsws_pkg::WAIT_MARK);
  assign wait_wc   = (cur.cyc == wsws_pkg::CM_WAIT) && !wait_sqz
                     && (cur.imp == wsws_pkg::WAIT_MARK);
  assign wait_hold = (cur.cyc == wsws_pkg::CM_WAIT) && !wait_sqz && !wait_wc
                     && (cur.hold == wsws_pkg::WAIT_MARK);
  assign in_wait   = (st_q == wsws_pkg::ST_SQZ && wait_sqz) || (st_q == wsws_pkg::ST_HOLD
                     && wait_hold) || ((st_q == wsws_pkg::ST_WELD || st_q == wsws_pkg::ST_COOL)
                     && wait_wc);
  assign tgt       = phase_len(st_q, cur);
  // Zero-length phases fall through at once
  assign done      = (tgt == 8'h00) || (tick && (cnt_q + 8'h01 == tgt));

  // Register writes; wait-here code without option 05 and oversized slope count refused
  always_comb begin
    accept = 1'b1;
    if (ADDR_I[3:0] == wsws_pkg::F_CYC && WR_DATA_I == wsws_pkg::CM_WAIT
        && opt_q != wsws_pkg::OPT_WAIT_EN) accept = 1'b0;
    if (ADDR_I[3:0] == wsws_pkg::F_SLC && WR_DATA_I > wsws_pkg::SLOPE_MAX) accept = 1'b0;
    mem_we  = WR_I && !ADDR_I[11] && (idx <= wsws_pkg::SCHED_LAST)
              && (ADDR_I[3:0] <= wsws_pkg::F_CONT) && accept;
    opt_d   = (WR_I && ADDR_I == wsws_pkg::A_OPTION) ? WR_DATA_I : opt_q;
    rd_d    = 8'h00;
    if (RD_I) begin
      if (!ADDR_I[11] && idx <= wsws_pkg::SCHED_LAST && ADDR_I[3:0] <= wsws_pkg::F_CONT)
        rd_d = mem[idx][{ADDR_I[3:0], 3'b000} +: 8];
      else if (ADDR_I == wsws_pkg::A_OPTION)     rd_d = opt_q;
      else if (ADDR_I == wsws_pkg::A_START)      rd_d = {1'b0, start_q};
      else if (ADDR_I == wsws_pkg::A_STAT_SCHED) rd_d = {1'b0, sched_q};
      else if (ADDR_I == wsws_pkg::A_STAT_STATE) rd_d = st_q;
    end
  end

  // Each field is its own byte, so one write never disturbs another
  always_ff @(posedge CORE_CLK_I) begin
    if (mem_we) mem[idx][{ADDR_I[3:0], 3'b000} +: 8] <= WR_DATA_I;
  end

  // Sequencer next state
  always_comb begin
    st_d = st_q; sched_d = sched_q; first_d = first_q; cnt_d = cnt_q; imp_d = imp_q;
    start_d = (WR_I && ADDR_I == wsws_pkg::A_START) ? WR_DATA_I[6:0] : start_q;
    if (tick) cnt_d = cnt_q + 8'h01;
    if (!ok) begin
      st_d = wsws_pkg::ST_IDLE;
    end else if (in_wait && (bra_r || brb_r)) begin
      sched_d = bra_r ? wsws_pkg::SCHED_BR_A : wsws_pkg::SCHED_BR_B;
      st_d = wsws_pkg::ST_SQZ; cnt_d = 8'h00; imp_d = 8'h00;
    end else begin
      case (st_q)
        wsws_pkg::ST_IDLE: begin
          if (prim_r) begin
            sched_d = start_q; first_d = start_q;
            st_d = wsws_pkg::ST_SQZ; cnt_d = 8'h00; imp_d = 8'h00;
          end
        end
        wsws_pkg::ST_SQZ: begin
          // Squeeze at 99 stays here; primary release is not looked at
          if (done && !wait_sqz) begin
            st_d = (cur.slm == wsws_pkg::SM_UP && cur.slc != 8'h00) ? wsws_pkg::ST_UPS
                   : wsws_pkg::ST_WELD;
            cnt_d = 8'h00;
          end
        end
        wsws_pkg::ST_UPS: begin
          if (done) begin st_d = wsws_pkg::ST_WELD; cnt_d = 8'h00; end
        end
        wsws_pkg::ST_WELD: begin
          if (done) begin st_d = wsws_pkg::ST_COOL; cnt_d = 8'h00; end
        end
        wsws_pkg::ST_COOL: begin
          if (done) begin
            cnt_d = 8'h00;
            imp_d = imp_q + 8'h01;
            if (wait_wc || imp_q + 8'h01 < cur.imp) st_d = wsws_pkg::ST_WELD;
            else if (cur.slm == wsws_pkg::SM_DOWN && cur.slc != 8'h00) st_d = wsws_pkg::ST_DNS;
            else st_d = wsws_pkg::ST_HOLD;
          end
        end
        wsws_pkg::ST_DNS: begin
          if (done) begin st_d = wsws_pkg::ST_HOLD; cnt_d = 8'h00; end
        end
        wsws_pkg::ST_HOLD: begin
          if (done && !wait_hold) begin
            cnt_d = 8'h00; imp_d = 8'h00;
            case (cur.cyc)
              wsws_pkg::CM_REPEAT: begin
                st_d = pin.prim ? wsws_pkg::ST_SQZ : wsws_pkg::ST_IDLE;
                sched_d = first_q;
              end
              wsws_pkg::CM_CHAIN: begin
                st_d = (sched_q == wsws_pkg::SCHED_LAST) ? wsws_pkg::ST_IDLE
                       : wsws_pkg::ST_SQZ;
                sched_d = sched_q + 7'h01;
              end
              wsws_pkg::CM_SUCC: begin
                st_d = wsws_pkg::ST_IDLE;
                start_d = (sched_q == wsws_pkg::SCHED_LAST) ? first_q : sched_q + 7'h01;
              end
              wsws_pkg::CM_CONDSUCC: st_d = wsws_pkg::ST_CSW;
              default: st_d = wsws_pkg::ST_IDLE;
            endcase
          end
        end
        wsws_pkg::ST_CSW: begin
          // A fresh closure only; a held switch must reopen first
          if (prim_r) begin
            st_d = (sched_q == wsws_pkg::SCHED_LAST) ? wsws_pkg::ST_IDLE : wsws_pkg::ST_SQZ;
            sched_d = sched_q + 7'h01; cnt_d = 8'h00;
          end
        end
        default: st_d = wsws_pkg::ST_IDLE;
      endcase
    end
  end

  // Output stage: valves, contactor, current, lamp
  always_comb begin
    valve_d = (st_q == wsws_pkg::ST_IDLE) ? 8'h00 : cur.valve;
    c1_d = 1'b0;
    c2_d = 1'b0;
    cur_d = 8'h00;
    if (st_q == wsws_pkg::ST_WELD || st_q == wsws_pkg::ST_UPS || st_q == wsws_pkg::ST_DNS) begin
      c2_d  = (cur.cont == wsws_pkg::CONT_2);
      c1_d  = !c2_d;
      cur_d = (st_q == wsws_pkg::ST_WELD) ? cur.pct : ramp_lvl;
    end
    blink_d = blink_q;
    lamp_d  = 1'b0;
    if (st_q == wsws_pkg::ST_CSW) begin
      lamp_d = lamp_q;
      if (tick) begin
        blink_d = blink_q + 8'h01;
        if (blink_q + 8'h01 >= wsws_pkg::BLINK_TICKS) begin
          blink_d = 8'h00;
          lamp_d  = !lamp_q;
        end
      end
    end else begin
      blink_d = 8'h00;
    end
  end

  assign ramp_load = (st_d != st_q) && (st_d == wsws_pkg::ST_UPS || st_d == wsws_pkg::ST_DNS);

  // Slope current
  wsws_ramp u_ramp (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESET_N_I),
    .load_i  (ramp_load),
    .up_i    (st_d == wsws_pkg::ST_UPS),
    .step_i  (tick && (st_q == wsws_pkg::ST_UPS || st_q == wsws_pkg::ST_DNS)),
    .pct_i   (cur.pct),
    .count_i (cur.slc),
    .level_o (ramp_lvl)
  );

  // Sequencer state and all outputs registered here
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q <= wsws_pkg::ST_IDLE; sched_q <= wsws_pkg::START_RST; first_q <= wsws_pkg::START_RST;
      start_q <= wsws_pkg::START_RST; opt_q <= wsws_pkg::OPTION_RST; cnt_q <= 8'h00;
      imp_q <= 8'h00; blink_q <= 8'h00; lamp_q <= 1'b0; pin_p_q <= '0;
      VALVE_O <= 8'h00; CONTACTOR1_O <= 1'b0; CONTACTOR2_O <= 1'b0; CURRENT_O <= 8'h00;
      HOLD_LAMP_O <= 1'b0; SCHED_O <= 7'h00; RD_DATA_O <= 8'h00;
    end else begin
      st_q <= st_d; sched_q <= sched_d; first_q <= first_d; start_q <= start_d;
      opt_q <= opt_d; cnt_q <= cnt_d; imp_q <= imp_d; blink_q <= blink_d;
      lamp_q <= lamp_d; pin_p_q <= pin;
      VALVE_O <= valve_d; CONTACTOR1_O <= c1_d; CONTACTOR2_O <= c2_d; CURRENT_O <= cur_d;
      HOLD_LAMP_O <= lamp_d; SCHED_O <= sched_q; RD_DATA_O <= rd_d;
    end
  end

  // Checks run on the core clock and rest while reset is low
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_valve_follow: assert property ($past(st_q) != wsws_pkg::ST_IDLE |-> VALVE_O == $past(cur.valve))
    else $error("valves differ from schedule code");
  a_contactor_two: assert property (CONTACTOR2_O |-> $past(cur.cont) == wsws_pkg::CONT_2)
    else $error("contactor 2 without select 02");
  a_contactor_one: assert property (
    CONTACTOR1_O |-> $past(cur.cont) != wsws_pkg::CONT_2)
    else $error("contactor 1 with select 02");
  a_upslope_start: assert property ($rose(st_q == wsws_pkg::ST_UPS) |=>
    CURRENT_O == {2'b00, $past(cur.pct[7:2])})
    else $error("upslope not from quarter current");
  a_hold_lamp: assert property (HOLD_LAMP_O |-> $past(st_q) == wsws_pkg::ST_CSW)
    else $error("hold lamp outside conditional wait");
  a_chain_next: assert property (ok && st_q == wsws_pkg::ST_HOLD && done
    && cur.cyc == wsws_pkg::CM_CHAIN && sched_q != wsws_pkg::SCHED_LAST
    |=> st_q == wsws_pkg::ST_SQZ && sched_q == $past(sched_q) + 7'h01)
    else $error("chain did not step to next schedule");
  a_wait_code_gate: assert property (WR_I && ADDR_I[3:0] == wsws_pkg::F_CYC && WR_DATA_I == wsws_pkg::CM_WAIT && opt_q != wsws_pkg::OPT_WAIT_EN |-> !mem_we)
    else $error("wait-here code accepted without option");
  a_stop_ends: assert property (!ok && st_q != wsws_pkg::ST_IDLE |=> st_q == wsws_pkg::ST_IDLE ##1 VALVE_O == 8'h00)
    else $error("sequence not stopped");
  a_branch_jump: assert property (ok && in_wait && bra_r |=> sched_q == wsws_pkg::SCHED_BR_A && st_q == wsws_pkg::ST_SQZ)
    else $error("branch A jump missing");
  a_wait_holds: assert property (ok && in_wait && !bra_r && !brb_r && st_q == wsws_pkg::ST_SQZ |=> st_q == wsws_pkg::ST_SQZ)
    else $error("wait-here left without cause");
  a_slope_limit: assert property (WR_I && ADDR_I[3:0] == wsws_pkg::F_SLC && WR_DATA_I > wsws_pkg::SLOPE_MAX |-> !mem_we)
    else $error("slope count above 99 stored");
  a_cond_restart: assert property (ok && st_q == wsws_pkg::ST_CSW && prim_r && sched_q != wsws_pkg::SCHED_LAST |=> st_q == wsws_pkg::ST_SQZ && sched_q == $past(sched_q) + 7'h01)
    else $error("re-initiation did not chain");
  a_weld_level: assert property ($past(st_q) == wsws_pkg::ST_WELD |-> CURRENT_O == $past(cur.pct))
    else $error("weld current not programmed level");
  c_cond_wait: cover property (st_q == wsws_pkg::ST_CSW ##1 st_q == wsws_pkg::ST_SQZ);
  c_upslope: cover property (st_q == wsws_pkg::ST_UPS ##1 st_q == wsws_pkg::ST_WELD);
  c_branch_b: cover property (in_wait && brb_r);
  c_downslope: cover property (st_q == wsws_pkg::ST_DNS ##1 st_q == wsws_pkg::ST_HOLD);
endmodule : wsws_top

// ---- dv/wsws_machine.sv ----
/*
  Machine side: free-running line tick and momentary operator switches.
  Assumes the bench calls press from its own clocked sequence.
*/
module wsws_machine (
  // Clock
  input  wire logic       clk_i,
  // Switches (0 prim, a, b, stop open, temp open) and line tick
  output logic      [4:0] sw_o,
  output logic            tick_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Mains tick, 40 clocks a period; the line never stops
  initial begin
    tick_o = 1'b0;
    forever begin
      repeat (20) @(posedge clk_i);
      tick_o <= ~tick_o;
    end
  end
  // Switches idle open, safety contacts closed
  initial sw_o = 5'h00;
  // Momentary change, long enough to pass the input synchroniser
  task automatic press(input int k);
    @(posedge clk_i);
    sw_o[k] <= 1'b1;
    repeat (12) @(posedge clk_i);
    sw_o[k] <= 1'b0;
  endtask : press
endmodule : wsws_machine

// ---- dv/wsws_tb_top.sv ----
/*
  Self-checking bench of the weld schedule sequencer.
  Assumes the register map and latencies of the designer's hand-over.
*/
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module wsws_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n, wr, rd, cont1, cont2, lamp, tick;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, valve, cur, d, f0, f1;
  logic [6:0]  sched;
  logic [4:0]  sw;
  logic [2:0]  w;
  int          errors, total_checks, n, t;
  logic [7:0]  msk [4] = '{8'h02, 8'h18, 8'h40, 8'h02};
  int          act [4] = '{2, 3, 4, 1};
  logic [15:0] lvl [3] = '{16'h4040, 16'h1040, 16'h4010};
  assign w = {lamp, cont2, cont1};
  wsws_machine u_mach (.clk_i(clk), .sw_o(sw), .tick_o(tick));
  wsws_top u_dut (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .PRIMARY_INITIATE_INPUT_I(sw[0]),
    .BRANCH_A_INITIATE_INPUT_I(sw[1]), .BRANCH_B_INITIATE_INPUT_I(sw[2]),
    .ESTOP_CLOSED_I(~sw[3]), .TEMP_LIMIT_CLOSED_I(~sw[4]), .LINE_TICK_I(tick),
    .VALVE_O(valve), .CONTACTOR1_O(cont1), .CONTACTOR2_O(cont2), .CURRENT_O(cur),
    .HOLD_LAMP_O(lamp), .SCHED_O(sched));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Register port cycles, one strobe cycle each
  task automatic wr8(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr8
  task automatic rd8(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : rd8
  // Whole schedule slot; cool and off stay zero
  task automatic prog(input int s, sqz, weld, pct, hold, imp, valv, cyc, slm, slc, cn);
    wsws_pkg::wsws_sched_type c;
    c = '{8'(cn), 8'(slc), 8'(slm), 8'(cyc), 8'(valv), 8'h00, 8'(imp), 8'h00,
          8'(hold), 8'(pct), 8'(weld), 8'(sqz)};
    for (int f = 0; f < 12; f++) begin
      wr8({1'b0, 7'(s), f[3:0]}, c[f*8 +: 8]);
    end
  endtask : prog
  task automatic go(input int s);
    wr8(wsws_pkg::A_START, 8'(s));
    u_mach.press(0);
  endtask : go
  // Bounded waits on contactor 1, contactor 2, lamp, or a schedule
  task automatic wait_on(input int k);
    for (n = 0; n < 4000 && w[k] !== 1'b1; n++) begin
      @(posedge clk);
    end
    `CHK(w[k], 1'b1)
  endtask : wait_on
  task automatic wait_sched(input logic [6:0] s);
    for (n = 0; n < 4000 && sched !== s; n++) begin
      @(posedge clk);
    end
    `CHK(sched, s)
  endtask : wait_sched
  // First and last current, and line ticks seen, while contactor 1 is on
  task automatic weld_run(output logic [7:0] a, output logic [7:0] b, output int c);
    logic p;
    int   g;
    a = 8'h00;
    b = 8'h00;
    c = 0;
    g = 0;
    wait_on(0);
    p = tick;
    // A zero-length cool opens the contactor for one clock before downslope
    for (n = 0; n < 2000 && g < 2; n++) begin
      g = (cont1 === 1'b1) ? 0 : g + 1;
      if (tick && !p) c++;
      p = tick;
      if (cur !== 8'h00 && a === 8'h00) a = cur;
      if (cur !== 8'h00) b = cur;
      @(posedge clk);
    end
  endtask : weld_run
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // Cut a hang well past the roughly 8000 cycles the run needs
  initial begin
    #2_000_000;
    errors++;
    close_out();
  end
  // Main sequence
  initial begin
    {rst_n, wr, rd, addr, wdata, errors, total_checks} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    `CHK(valve, 8'h00)
    // Counts kept apart; a slope count past 99 is refused
    wr8(12'h0A1, 8'h11);
    wr8(12'h0AA, 8'h63);
    wr8(12'h0AA, 8'h64);
    rd8(12'h0A1, d);
    `CHK(d, 8'h11)
    rd8(12'h0AA, d);
    `CHK(d, 8'h63)
    rd8(12'h0AC, d);
    `CHK(d, 8'h00)
    // Wait-here code only after the option holds 05
    wr8(12'h0A8, 8'h00);
    wr8(12'h0A8, 8'h05);
    rd8(12'h0A8, d);
    `CHK(d, 8'h00)
    wr8(wsws_pkg::A_OPTION, 8'h05);
    wr8(12'h0A8, 8'h05);
    rd8(12'h0A8, d);
    `CHK(d, 8'h05)
    // Chained pair: valve code and contactor follow the running schedule
    prog(0, 1, 2, 8'h46, 1, 1, 8'h07, 8'h02, 0, 0, 8'h01);
    prog(1, 0, 2, 8'h46, 1, 1, 8'h0B, 8'h00, 0, 0, 8'h02);
    go(0);
    wait_on(0);
    `CHK({sched, valve, cont2}, {7'h00, 8'h07, 1'b0})
    wait_on(1);
    `CHK({sched, valve, cont1}, {7'h01, 8'h0B, 1'b0})
    // Let the chain finish, or the next initiation lands mid-weld
    repeat (400) @(posedge clk);
    // Conditional successive: valves held, lamp blinks, fresh closure goes on
    prog(5, 1, 0, 0, 1, 1, 8'h01, 8'h04, 0, 0, 8'h01);
    prog(6, 1, 0, 0, 1, 1, 8'h03, 8'h00, 0, 0, 8'h01);
    go(5);
    wait_on(2);
    rd8(wsws_pkg::A_STAT_STATE, d);
    `CHK({d, valve}, 16'h8001)
    u_mach.press(0);
    wait_sched(7'h06);
    repeat (2) @(posedge clk);
    `CHK(valve, 8'h03)
    repeat (400) @(posedge clk);
    // Wait-here at each wait point, left by branch, stop or temperature
    prog(20, 1, 0, 0, 1, 1, 8'h10, 8'h00, 0, 0, 8'h01);
    prog(40, 1, 0, 0, 1, 1, 8'h20, 8'h00, 0, 0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      prog(3, i % 3 ? 1 : 99, 1, 8'h30, i == 2 ? 99 : 1, i == 1 ? 99 : 1,
           8'h07, 8'h05, 0, 0, 8'h01);
      go(3);
      repeat (400) @(posedge clk);
      rd8(wsws_pkg::A_STAT_STATE, d);
      `CHK(|(d & msk[i]), 1'b1)
      `CHK(valve, 8'h07)
      u_mach.press(act[i]);
      if (i == 1 || i == 2) begin
        `CHK(valve, 8'h00)
      end else begin
        wait_sched(i ? 7'h14 : 7'h28);
        repeat (2) @(posedge clk);
        `CHK(valve, i ? 8'h10 : 8'h20)
      end
      repeat (400) @(posedge clk);
    end
    // Slope modes none, up, down: current levels and ticks of current
    for (int m = 0; m < 3; m++) begin
      prog(8, 1, 2, 8'h40, 1, 1, 8'h01, 8'h00, m, 4, 8'h01);
      go(8);
      weld_run(f0, f1, t);
      `CHK({f0, f1}, lvl[m])
      `CHK(t, m ? 6 : 2)
      repeat (200) @(posedge clk);
    end
    // Successive: ends idle, start register stepped to the next schedule
    prog(9, 1, 0, 0, 1, 1, 8'h01, 8'h03, 0, 0, 8'h01);
    go(9);
    repeat (400) @(posedge clk);
    rd8(wsws_pkg::A_START, d);
    `CHK(d, 8'h0A)
    rd8(wsws_pkg::A_STAT_SCHED, d);
    `CHK(d, 8'h09)
    close_out();
  end
endmodule : wsws_tb_top
